// ==== hw/spl_pkg.sv ====
// Constants shared by the serial pattern-load block.
// Assumes a 25 MHz register clock and a 32-bit APB register port.
package spl_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] CFG_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] WORD_SEL_OFFSET = 12'h008;
    localparam logic [11:0] WORD_DATA_OFFSET = 12'h00c;

    // ==========================================================
    // Field positions and reset values
    localparam int CFG_WIDTH_LSB = 0;
    localparam int CFG_CLEAR_BIT = 8;
    localparam int STATUS_FULL_BIT = 8;
    localparam logic [2:0] WIDTH_X4 = 3'h2;
    localparam logic [2:0] WIDTH_X8 = 3'h3;
    localparam logic [2:0] WIDTH_X16 = 3'h4;
    localparam logic [2:0] CFG_WIDTH_RESET = WIDTH_X16;

    // ==========================================================
    // Column geometry
    localparam int BYTE_BITS = 8;
    localparam int CORE_WORDS = 16;
    localparam int WORD_BITS = 16;
    localparam int COLUMN_BITS = CORE_WORDS * WORD_BITS;
    localparam int COLUMN_BYTES = COLUMN_BITS / BYTE_BITS;
    localparam logic [5:0] COLUMN_BYTES_CNT = 6'h20;
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;

    // Core word that receives each load word, in load order
    localparam int LOAD_TO_CORE [16] = '{15, 7, 11, 3, 13, 5, 9, 1,
                                         0, 8, 4, 12, 2, 10, 6, 14};
    // Core-word bit carried by serial field bit i, first byte
    localparam int SER_BYTE0 [8] = '{2, 6, 10, 14, 3, 7, 11, 15};
    // Core-word bit carried by serial field bit i, second byte
    localparam int SER_BYTE1 [8] = '{0, 4, 8, 12, 1, 5, 9, 13};

    // Write-enable patterns
    localparam logic [15:0] WE_ALL = 16'hffff;
    localparam logic [15:0] WE_LOW_HALF = 16'h00ff;
    localparam logic [15:0] WE_HIGH_HALF = 16'hff00;
    localparam logic [15:0] WE_QUARTER = 16'h000f;
    localparam logic [15:0] WE_NONE = 16'h0000;

endpackage

// ==== hw/spl_sync.sv ====
// Two-flop level synchroniser into the register clock domain.
// Assumes the input is a slow level or toggle from another clock.
`timescale 1ns/1ps
`default_nettype none
module spl_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);

    logic meta_ff;

    // First stage read only by second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end

endmodule
`default_nettype wire

// ==== hw/spl_top.sv ====
// Serial pattern-load holding register with width-dependent write select.
// Assumes a packet decoder on the serial clock flags the data bits of a
// pattern-load packet, and a command decoder pulses column writes on CLK.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - each packet brings one byte, shifted in
// - every packet advances holding shifter eight bits
// - one packet type for all widths
// - full packet sequence fills one column
// - narrow widths split column into sub-columns
// - sub-column bits choose written core words
// - load words map to fixed core words
// - core word bits are symbols t0..t15
// - two bytes per word, fixed bit scramble
// - serial field sent bit seven first
// - serial inputs sampled on falling clock
// - width field: x4, x8, x16 codes
module spl_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Serial link side
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_CMD,
    input wire logic SERIAL_LOAD_EN,
    // Column write request from the command decoder
    input wire logic WR_STROBE,
    input wire logic [3:0] SUB_COLUMN_SELECT,
    // Core write port
    output logic CORE_WR,
    output logic [15:0] CORE_WE,
    output logic [spl_pkg::COLUMN_BITS-1:0] CORE_DATA,
    output logic COLUMN_FULL,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    import spl_pkg::*;

    // ==========================================================
    // Link domain: falling-edge serial byte capture
    logic [6:0] link_sr_ff;
    logic [2:0] link_cnt_ff;
    logic [7:0] link_byte_ff;
    logic link_tgl_ff;
    logic link_last;
    logic [7:0] link_full_byte;

    // Byte completes on the eighth flagged bit
    assign link_last = SERIAL_LOAD_EN && (link_cnt_ff == LAST_BIT_IDX);
    assign link_full_byte = {link_sr_ff, SERIAL_CMD};

    // Shift and count on each falling serial edge with SERIAL_LOAD_EN high
    always_ff @(negedge SERIAL_CLK or negedge RST_N) begin
        if (!RST_N) begin
            link_sr_ff <= 7'h00;
            link_cnt_ff <= 3'h0;
        end else if (SERIAL_LOAD_EN) begin
            link_sr_ff <= link_full_byte[6:0];
            link_cnt_ff <= link_cnt_ff + 3'h1;
        end
    end

    // Hold finished byte and flag it by a toggle
    always_ff @(negedge SERIAL_CLK or negedge RST_N) begin
        if (!RST_N) begin
            link_byte_ff <= 8'h00;
            link_tgl_ff <= 1'b0;
        end else if (link_last) begin
            link_byte_ff <= link_full_byte;
            link_tgl_ff <= ~link_tgl_ff;
        end
    end

    // ==========================================================
    // Crossing into the register domain
    logic tgl_sync;
    logic tgl_seen_ff;
    logic byte_take;

    spl_sync u_tgl_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .d(link_tgl_ff),
        .q(tgl_sync)
    );

    // Byte stays stable for eight serial bits after the toggle
    assign byte_take = CE && (tgl_sync != tgl_seen_ff);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tgl_seen_ff <= 1'b0;
        end else if (CE) begin
            tgl_seen_ff <= tgl_sync;
        end
    end

    // ==========================================================
    // Holding shifter and fill count
    logic [COLUMN_BITS-1:0] shifter_ff;
    logic [COLUMN_BITS-1:0] nxt_shifter;
    logic [5:0] fill_cnt_ff;
    logic [5:0] nxt_fill_cnt;
    logic full_ff;
    logic clear_req;
    logic cnt_at_full;

    // Same shift for every width, newest byte at the low end
    assign nxt_shifter = {shifter_ff[COLUMN_BITS-BYTE_BITS-1:0],
                          link_byte_ff};
    assign cnt_at_full = (fill_cnt_ff == COLUMN_BYTES_CNT);
    // Count saturates; a byte landing with a clear counts as the first
    assign nxt_fill_cnt = clear_req ? {5'h00, byte_take} :
                          (byte_take && !cnt_at_full) ?
                          fill_cnt_ff + 6'h01 : fill_cnt_ff;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            shifter_ff <= '0;
        end else if (byte_take) begin
            shifter_ff <= nxt_shifter;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fill_cnt_ff <= 6'h00;
            full_ff <= 1'b0;
        end else if (CE) begin
            fill_cnt_ff <= nxt_fill_cnt;
            full_ff <= (nxt_fill_cnt == COLUMN_BYTES_CNT);
        end
    end

    // ==========================================================
    // Unscramble shifter into core words
    logic [COLUMN_BITS-1:0] held_flat;
    logic [WORD_BITS-1:0] held_core_word [CORE_WORDS];

    // Load word w: first byte is older, sits higher in the shifter
    for (genvar w = 0; w < CORE_WORDS; w++) begin : g_word
        for (genvar i = 0; i < BYTE_BITS; i++) begin : g_bit
            assign held_flat[WORD_BITS*LOAD_TO_CORE[w] + SER_BYTE0[i]] =
                shifter_ff[BYTE_BITS*(COLUMN_BYTES-1-2*w) + i];
            assign held_flat[WORD_BITS*LOAD_TO_CORE[w] + SER_BYTE1[i]] =
                shifter_ff[BYTE_BITS*(COLUMN_BYTES-2-2*w) + i];
        end
        // Bit n of a core word is symbol time tn
        assign held_core_word[w] = held_flat[WORD_BITS*w +: WORD_BITS];
    end

    // ==========================================================
    // Registers
    logic [2:0] width_ff;
    logic [3:0] word_sel_ff;
    logic apb_fire;
    logic apb_wr;
    logic hit_cfg;
    logic hit_status;
    logic hit_sel;
    logic hit_data;
    logic hit_any;
    logic [31:0] rd_mux;

    // Address decode and read selection
    assign apb_fire = PSEL && PENABLE && PREADY;
    assign apb_wr = apb_fire && PWRITE;
    assign hit_cfg = (PADDR == CFG_OFFSET);
    assign hit_status = (PADDR == STATUS_OFFSET);
    assign hit_sel = (PADDR == WORD_SEL_OFFSET);
    assign hit_data = (PADDR == WORD_DATA_OFFSET);
    assign hit_any = hit_cfg || hit_status || hit_sel || hit_data;
    assign clear_req = apb_wr && hit_cfg && PWDATA[CFG_CLEAR_BIT];
    assign rd_mux = hit_cfg ? {29'h0, width_ff} :
                    hit_status ? {23'h0, full_ff, 2'h0, fill_cnt_ff} :
                    hit_sel ? {28'h0, word_sel_ff} :
                    hit_data ? {16'h0, held_core_word[word_sel_ff]} :
                    32'h0;

    // Width field steers the write select
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            width_ff <= CFG_WIDTH_RESET;
            word_sel_ff <= 4'h0;
        end else if (CE && apb_wr) begin
            if (hit_cfg) begin
                width_ff <= PWDATA[CFG_WIDTH_LSB +: 3];
            end
            if (hit_sel) begin
                word_sel_ff <= PWDATA[3:0];
            end
        end
    end

    // One wait state, then ready with data and error
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY <= PSEL && PENABLE && !PREADY;
            PRDATA <= (PSEL && PENABLE && !PREADY && !PWRITE) ?
                      rd_mux : 32'h0;
            PSLVERR <= PSEL && PENABLE && !PREADY && !hit_any;
        end
    end

    // ==========================================================
    // Sub-column write select
    logic [15:0] we_x8;
    logic [15:0] we_x4;
    logic [15:0] we_sel;
    logic [1:0] sc_hi;

    // Sub-column count follows native over programmed width
    assign sc_hi = SUB_COLUMN_SELECT[3:2];
    assign we_x8 = sc_hi[1] ? WE_HIGH_HALF : WE_LOW_HALF;
    assign we_x4 = WE_QUARTER << {sc_hi, 2'b00};
    assign we_sel = (width_ff == WIDTH_X16) ? WE_ALL :
                    (width_ff == WIDTH_X8) ? we_x8 :
                    (width_ff == WIDTH_X4) ? we_x4 : WE_NONE;

    // Each write moves the held column with its enables
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CORE_WR <= 1'b0;
            CORE_WE <= WE_NONE;
            CORE_DATA <= '0;
        end else if (CE) begin
            CORE_WR <= WR_STROBE;
            if (WR_STROBE) begin
                CORE_WE <= we_sel;
                CORE_DATA <= held_flat;
            end
        end
    end

    // Column status pin
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            COLUMN_FULL <= 1'b0;
        end else if (CE) begin
            COLUMN_FULL <= (nxt_fill_cnt == COLUMN_BYTES_CNT);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_apb_wait;
        PSEL && PENABLE && !PREADY && CE;
    endsequence

    sequence s_wr_req(logic [2:0] wcode);
        WR_STROBE && CE && width_ff == wcode;
    endsequence

    a_shift_by_byte: assert property (
        byte_take |=> shifter_ff[COLUMN_BITS-1:BYTE_BITS] ==
            $past(shifter_ff[COLUMN_BITS-BYTE_BITS-1:0]) &&
            shifter_ff[7:0] == $past(link_byte_ff))
        else $error("shifter did not advance by one byte");

    a_fill_advance: assert property (
        byte_take && !clear_req && fill_cnt_ff < COLUMN_BYTES_CNT
        |=> fill_cnt_ff == $past(fill_cnt_ff) + 6'h01)
        else $error("fill count did not advance");

    a_full_pin_match: assert property (
        CE |=> COLUMN_FULL == (fill_cnt_ff == 6'h20))
        else $error("column full pin disagrees with count");

    a_x16_all_words: assert property (
        s_wr_req(WIDTH_X16) |=> CORE_WR && CORE_WE == 16'hffff)
        else $error("x16 write must enable every word");

    a_x8_half_words: assert property (
        s_wr_req(WIDTH_X8) |=> CORE_WE ==
            ($past(SUB_COLUMN_SELECT[3]) ? 16'hff00 : 16'h00ff))
        else $error("x8 write enabled the wrong half");

    a_x4_quarter_words: assert property (
        s_wr_req(WIDTH_X4) && sc_hi == 2'h2 |=> CORE_WE == 16'h0f00)
        else $error("x4 write enabled the wrong quarter");

    a_load_order_map: assert property (
        held_core_word[15][15] == shifter_ff[255] &&
        held_core_word[0][0] == shifter_ff[112] &&
        held_core_word[14][0] == shifter_ff[0])
        else $error("load word to core word map broken");

    a_write_data_copy: assert property (
        WR_STROBE && CE |=> CORE_DATA == $past(held_flat))
        else $error("core data not taken from holding register");

    a_apb_one_wait: assert property (
        s_apb_wait |=> PREADY ##1 !PREADY)
        else $error("APB ready not a single pulse after one wait");

    a_clear_restart: assert property (
        clear_req && CE |=> fill_cnt_ff == {5'h00, $past(byte_take)})
        else $error("fill count not restarted by clear");

    a_core_wr_pulse: assert property (
        CE && !WR_STROBE |=> !CORE_WR)
        else $error("core write without a request");

    a_prdata_idle: assert property (
        !PREADY |-> PRDATA == 32'h0)
        else $error("read data shown outside the ready cycle");

    a_ce_freeze: assert property (
        !CE |=> $stable(fill_cnt_ff) && $stable(width_ff) &&
            $stable(CORE_WR) && $stable(PREADY))
        else $error("state moved while clock enable was low");

    property p_link_byte_done;
        @(negedge SERIAL_CLK) disable iff (!RST_N)
        link_last |=> link_tgl_ff != $past(link_tgl_ff) &&
            link_byte_ff[0] == $past(SERIAL_CMD);
    endproperty
    a_link_byte_done: assert property (p_link_byte_done)
        else $error("serial byte not completed on eighth bit");

endmodule
`default_nettype wire

// ==== verif/serial_pattern_load_tb.sv ====
// Self-checking bench for the serial pattern-load block.
// Assumes spl_pkg is compiled first and spl_link_model drives the link.
`timescale 1ns/1ps
`default_nettype none
module serial_pattern_load_tb;
    import spl_pkg::*;
    logic clk, rst_n, ce, wr_strobe, psel, penable, pwrite, err;
    logic [3:0] sc;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, prdata;
    logic core_wr, column_full, pready, pslverr;
    logic [15:0] core_we;
    logic [255:0] core_data;
    logic [15:0] col [16];
    wire logic s_clk, s_cmd, s_en;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int ord [16] = '{15, 7, 11, 3, 13, 5, 9, 1, 0, 8, 4, 12, 2, 10, 6, 14};

    // ==========================================================
    // Block and far end
    spl_top u_spl_top (.CLK(clk), .RST_N(rst_n), .CE(ce),
        .SERIAL_CLK(s_clk), .SERIAL_CMD(s_cmd), .SERIAL_LOAD_EN(s_en),
        .WR_STROBE(wr_strobe), .SUB_COLUMN_SELECT(sc), .CORE_WR(core_wr),
        .CORE_WE(core_we), .CORE_DATA(core_data),
        .COLUMN_FULL(column_full), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr));
    spl_link_model u_spl_link_model (.ser_clk(s_clk), .ser_cmd(s_cmd),
        .ser_en(s_en));

    // ==========================================================
    // Helpers
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // APB transfer: held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) n_errors++;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a,
                          input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(name, rd, e);
        check("rd_err", 32'(err), 32'h0);
    endtask

    function automatic logic [15:0] scramble(input logic [15:0] d);
        return {d[15], d[11], d[7], d[3], d[14], d[10], d[6], d[2],
                d[13], d[9], d[5], d[1], d[12], d[8], d[4], d[0]};
    endfunction

    function automatic logic [15:0] exp_we(input logic [2:0] w,
                                           input logic [3:0] s);
        case (w)
            3'h4: return 16'hffff;
            3'h3: return s[3] ? 16'hff00 : 16'h00ff;
            3'h2: return 16'h000f << (4 * s[3:2]);
            default: return 16'h0000;
        endcase
    endfunction

    task automatic load_word(input logic [15:0] w);
        logic [15:0] s;
        s = scramble(w);
        u_spl_link_model.send_byte(s[15:8]);
        u_spl_link_model.send_byte(s[7:0]);
    endtask

    task automatic chk_words();
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, WORD_SEL_OFFSET, 32'(c));
            rd_chk("word_data", WORD_DATA_OFFSET, 32'(col[c]));
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd_chk("cfg", CFG_OFFSET, 32'h4);
        rd_chk("status", STATUS_OFFSET, 32'h0);
        apb(1'b0, 12'h0f0, 32'h0);
        check("unmapped_err", 32'(err), 32'h1);
        check("unmapped_rd", rd, 32'h0);
    endtask

    task automatic t_load();
        logic [15:0] s;
        for (int j = 0; j < 16; j++) begin
            col[ord[j]] = 16'(16'h9e37 * (j + 1));
            if (j < 15) load_word(col[ord[j]]);
        end
        s = scramble(col[ord[15]]);
        u_spl_link_model.send_byte(s[15:8]);
        repeat (8) @(posedge clk);
        check("full_early", 32'(column_full), 32'h0);
        rd_chk("status", STATUS_OFFSET, 32'h1f);
        u_spl_link_model.send_byte(s[7:0]);
        repeat (8) @(posedge clk);
        check("full", 32'(column_full), 32'h1);
        rd_chk("status", STATUS_OFFSET, 32'h120);
        chk_words();
    endtask

    // Back-to-back column writes over every select value and width
    task automatic t_write();
        logic [2:0] wd [4] = '{3'h4, 3'h3, 3'h2, 3'h0};
        foreach (wd[i]) begin
            apb(1'b1, CFG_OFFSET, 32'(wd[i]));
            @(posedge clk);
            wr_strobe <= 1'b1;
            sc <= 4'h0;
            for (int k = 0; k < 16; k++) begin
                @(posedge clk);
                sc <= 4'(k + 1);
                wr_strobe <= (k < 15);
                #1;
                check("core_wr", 32'(core_wr), 32'h1);
                check("core_we", 32'(core_we),
                      32'(exp_we(wd[i], 4'(k))));
                if (wd[i] == 3'h4 && k == 0) begin
                    for (int n = 0; n < 16; n++) begin
                        check("core_data", 32'(core_data[16*n+:16]),
                              32'(col[n]));
                    end
                end
            end
            @(posedge clk);
            #1;
            check("core_wr_end", 32'(core_wr), 32'h0);
        end
    endtask

    // Extra word shifts the column along, then the fill count is cleared
    task automatic t_shift();
        logic [15:0] old [16];
        old = col;
        for (int j = 0; j < 16; j++) begin
            col[ord[j]] = (j < 15) ? old[ord[j + 1]] : 16'h3c5a;
        end
        load_word(16'h3c5a);
        repeat (8) @(posedge clk);
        chk_words();
        rd_chk("status_sat", STATUS_OFFSET, 32'h120);
        apb(1'b1, CFG_OFFSET, 32'h104);
        rd_chk("status_clr", STATUS_OFFSET, 32'h0);
        check("full_clr", 32'(column_full), 32'h0);
    endtask

    // Clock enable low: a write request is ignored and nothing moves
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        wr_strobe <= 1'b1;
        sc <= 4'h8;
        @(posedge clk);
        wr_strobe <= 1'b0;
        #1;
        check("core_wr_frozen", 32'(core_wr), 32'h0);
        check("core_we_frozen", 32'(core_we), 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk("cfg_frozen", CFG_OFFSET, 32'h4);
    endtask

    // ==========================================================
    // Clock, timeout and main sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 10000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        wr_strobe = 1'b0;
        sc = 4'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_load();
        t_write();
        t_shift();
        t_freeze();
        close_out();
    end
endmodule
`default_nettype wire

// ==== verif/spl_link_model.sv ====
// Controller-side model of the serial command link for pattern loads.
// Assumes the device samples on the falling edge of the serial clock.
`timescale 1ns/1ps
`default_nettype none
module spl_link_model (
    output logic ser_clk,
    output logic ser_cmd,
    output logic ser_en
);
    // ==========================================================
    // Idle state and one clock fall inside reset
    initial begin
        ser_clk = 1'b1;
        ser_cmd = 1'b0;
        ser_en = 1'b0;
        #53 ser_clk = 1'b0;
        #15 ser_clk = 1'b1;
    end

    // ==========================================================
    // One packet data field: bit 7 first, clock parked high after
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            ser_en = 1'b1;
            ser_cmd = b[i];
            #15 ser_clk = 1'b0;
            #15 ser_clk = 1'b1;
        end
        #5 ser_en = 1'b0;
        ser_cmd = ~ser_cmd; // Stale data line never holds its value
        #150;
    endtask
endmodule
`default_nettype wire
